// ### logic/link_err_strap_pkg.sv
// Constants, field layouts and state carriers for the link error and
// strap status register slice.
// Assumes an 8-bit register port and one clock (the recovered pixel clock).
package link_err_strap_pkg;

  // Register offsets.
  localparam logic [7:0] OFS_RESERVED_B5   = 8'hB5;
  localparam logic [7:0] OFS_RESERVED_B6   = 8'hB6;
  localparam logic [7:0] OFS_RESERVED_B7   = 8'hB7;
  localparam logic [7:0] OFS_STRAP_STATUS  = 8'hB8;
  localparam logic [7:0] OFS_LINK_ERR_CTL  = 8'hB9;
  localparam logic [7:0] OFS_ENC_CRC_CTL   = 8'hBA;
  localparam logic [7:0] OFS_RESERVED_BB   = 8'hBB;

  // Values after reset.
  localparam logic [7:0] RST_RESERVED_B5   = 8'h00;
  localparam logic [7:0] RST_RESERVED_B6   = 8'h18;
  localparam logic [7:0] RST_RESERVED_B7   = 8'h00;
  localparam logic [7:0] RST_RESERVED_BB   = 8'h74;
  localparam logic       RST_IGNORE_WAIT   = 1'h1;
  localparam logic       RST_COUNT_EN      = 1'h1;
  localparam logic [3:0] RST_THRESHOLD     = 4'h3;
  localparam logic       RST_CRC_DISABLE   = 1'h0;
  localparam logic [6:0] RST_ENC_RESERVED  = 7'h03;

  // Field positions.
  localparam int BIT_INDEX_DONE   = 7;
  localparam int LSB_INDEX_VALUE  = 4;
  localparam int BIT_CONFIG_DONE  = 3;
  localparam int LSB_CONFIG_VALUE = 0;
  localparam int BIT_IGNORE_WAIT  = 5;
  localparam int BIT_COUNT_EN     = 4;
  localparam int LSB_THRESHOLD    = 0;
  localparam int BIT_CRC_DISABLE  = 7;

  localparam int STRAP_W = 3;
  localparam int NUM_STRAPS = 2;

  typedef enum logic [0:0] {
    LINK_UNLOCKED = 1'b0,
    LINK_LOCKED   = 1'b1
  } link_state_e;

  typedef struct packed {
    logic               done;
    logic [STRAP_W-1:0] value;
  } strap_state_s;

  typedef struct packed {
    logic [7:0]  rsvd_b5;
    logic [7:0]  rsvd_b6;
    logic [7:0]  rsvd_b7;
    logic [7:0]  rsvd_bb;
    logic        ignore_errors_in_filter_wait;
    logic        count_en;
    logic [3:0]  lock_drop_threshold;
    logic        encoder_crc_disable;
    logic [6:0]  enc_reserved;
    link_state_e link_state;
    logic [3:0]  error_count;
    logic        lock_detect_prev;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  link_info;
    logic        link_info_upd;
  } bank_state_s;

endpackage

// ### logic/strap_capture.sv
// Latches one decoded strap value and flags completion.
// Assumes the decoder pulses i_decode_valid with a settled value.
`timescale 1ns/1ps
`default_nettype none
module strap_capture
  import link_err_strap_pkg::*;
(
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  // Decoder side
  input  wire logic               i_decode_valid,
  input  wire logic [STRAP_W-1:0] i_decode_value,
  // Latched result
  output logic                    o_done,
  output logic [STRAP_W-1:0]      o_value
);
  strap_state_s st_q;
  strap_state_s st_d;

  // The first result is kept; later pulses cannot disturb a read value.
  always_comb begin
    st_d = st_q;
    if (i_decode_valid && !st_q.done) begin
      st_d.value = i_decode_value;
      st_d.done  = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_done  = st_q.done;
  assign o_value = st_q.value;
endmodule
`default_nettype wire

// ### logic/link_err_strap_bank.sv
// Register slice: strap decode status, link error lock monitor and
// encoder CRC gate for link information updates.
// Assumes i_sys_clk is the recovered pixel clock and that every input is
// synchronous to it. Register reads answer one cycle after the strobe.
//
// Functional notes
// - Index strap done flag at status bit 7.
// - Index strap value read at bits 6:4.
// - Config strap done flag at status bit 3.
// - Config strap value read at bits 2:0.
// - Bit 5 ignores errors in filter wait.
// - Count errors only while bit 4 set.
// - Drop lock when count reaches threshold.
// - Counting disabled: first error drops lock.
// - Parity, clock, control violations count as errors.
// - Bit 7 clear: failed CRC blocks updates.
`timescale 1ns/1ps
`default_nettype none
module link_err_strap_bank
  import link_err_strap_pkg::*;
(
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_reset,
  // Register port
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  input  wire logic [7:0]         i_reg_wdata,
  output logic [7:0]              o_reg_rdata,
  output logic                    o_reg_rvalid,
  // Strap decoders
  input  wire logic               i_index_strap_valid,
  input  wire logic [STRAP_W-1:0] i_index_strap_code,
  input  wire logic               i_config_strap_valid,
  input  wire logic [STRAP_W-1:0] i_config_strap_code,
  // Forward link monitor
  input  wire logic               i_lock_detect,
  input  wire logic               i_parity_err,
  input  wire logic               i_clock_err,
  input  wire logic               i_control_err,
  input  wire logic               i_filter_wait,
  output logic                    o_link_lock,
  // Encoded link information sequences
  input  wire logic               i_enc_valid,
  input  wire logic               i_enc_crc_ok,
  input  wire logic [7:0]         i_enc_info,
  output logic [7:0]              o_link_info,
  output logic                    o_link_info_upd
);

  bank_state_s        st_q;
  bank_state_s        st_d;
  logic [NUM_STRAPS-1:0] strap_done;
  logic [STRAP_W-1:0] strap_value [NUM_STRAPS];
  logic [NUM_STRAPS-1:0] strap_valid;
  logic [STRAP_W-1:0] strap_code [NUM_STRAPS];
  logic               link_error;
  logic               counted_error;
  logic [4:0]         count_inc;
  logic [7:0]         status_byte;

  assign strap_valid   = {i_config_strap_valid, i_index_strap_valid};
  assign strap_code[0] = i_index_strap_code;
  assign strap_code[1] = i_config_strap_code;

  genvar g;
  generate
    for (g = 0; g < NUM_STRAPS; g++) begin : g_strap
      strap_capture u_cap (
        .i_sys_clk      (i_sys_clk),
        .i_reset        (i_reset),
        .i_decode_valid (strap_valid[g]),
        .i_decode_value (strap_code[g]),
        .o_done         (strap_done[g]),
        .o_value        (strap_value[g])
      );
    end
  endgenerate

  always_comb begin
    status_byte = 8'h00;
    status_byte[BIT_INDEX_DONE] = strap_done[0];
    status_byte[LSB_INDEX_VALUE +: STRAP_W] = strap_value[0];
    status_byte[BIT_CONFIG_DONE] = strap_done[1];
    status_byte[LSB_CONFIG_VALUE +: STRAP_W] = strap_value[1];
  end

  assign link_error = i_parity_err | i_clock_err | i_control_err;
  // Errors in the filter settling window are dropped only when enabled.
  assign counted_error = link_error &
      !(st_q.ignore_errors_in_filter_wait && i_filter_wait);
  assign count_inc = {1'b0, st_q.error_count} + 5'h01;

  always_comb begin
    st_d = st_q;
    st_d.rvalid = 1'b0;
    st_d.link_info_upd = 1'b0;
    st_d.lock_detect_prev = i_lock_detect;

    if (i_reg_wr) begin
      case (i_reg_addr)
        OFS_RESERVED_B5: st_d.rsvd_b5 = i_reg_wdata;
        OFS_RESERVED_B6: st_d.rsvd_b6 = i_reg_wdata;
        OFS_RESERVED_B7: st_d.rsvd_b7 = i_reg_wdata;
        OFS_RESERVED_BB: st_d.rsvd_bb = i_reg_wdata;
        OFS_LINK_ERR_CTL: begin
          st_d.ignore_errors_in_filter_wait = i_reg_wdata[BIT_IGNORE_WAIT];
          st_d.count_en = i_reg_wdata[BIT_COUNT_EN];
          st_d.lock_drop_threshold = i_reg_wdata[LSB_THRESHOLD +: 4];
        end
        OFS_ENC_CRC_CTL: begin
          st_d.encoder_crc_disable = i_reg_wdata[BIT_CRC_DISABLE];
          st_d.enc_reserved = i_reg_wdata[6:0];
        end
        default: ;
      endcase
    end

    if (i_reg_rd) begin
      st_d.rvalid = 1'b1;
      case (i_reg_addr)
        OFS_RESERVED_B5:  st_d.rdata = st_q.rsvd_b5;
        OFS_RESERVED_B6:  st_d.rdata = st_q.rsvd_b6;
        OFS_RESERVED_B7:  st_d.rdata = st_q.rsvd_b7;
        OFS_RESERVED_BB:  st_d.rdata = st_q.rsvd_bb;
        OFS_STRAP_STATUS: st_d.rdata = status_byte;
        OFS_LINK_ERR_CTL: st_d.rdata = {2'b00,
            st_q.ignore_errors_in_filter_wait, st_q.count_en,
            st_q.lock_drop_threshold};
        OFS_ENC_CRC_CTL:  st_d.rdata = {st_q.encoder_crc_disable,
            st_q.enc_reserved};
        default:          st_d.rdata = 8'h00;
      endcase
    end

    // Lock monitor. A new lock needs a fresh rising edge of the detector,
    // otherwise a dropped link would relock in the very next cycle.
    case (st_q.link_state)
      LINK_UNLOCKED: begin
        if (i_lock_detect && !st_q.lock_detect_prev) begin
          st_d.link_state = LINK_LOCKED;
          st_d.error_count = 4'h0;
        end
      end
      LINK_LOCKED: begin
        if (!i_lock_detect) begin
          st_d.link_state = LINK_UNLOCKED;
        end else if (counted_error) begin
          if (!st_q.count_en) begin
            st_d.link_state = LINK_UNLOCKED;
          end else if (count_inc >= {1'b0, st_q.lock_drop_threshold}) begin
            st_d.link_state = LINK_UNLOCKED;
            st_d.error_count = st_q.lock_drop_threshold;
          end else begin
            st_d.error_count = count_inc[3:0];
          end
        end
      end
      default: st_d.link_state = LINK_UNLOCKED;
    endcase

    // A failed sequence touches the stored link information only while encoder_crc_disable is set.
    if (i_enc_valid && (i_enc_crc_ok || st_q.encoder_crc_disable)) begin
      st_d.link_info = i_enc_info;
      st_d.link_info_upd = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
      st_q.rsvd_b5 <= RST_RESERVED_B5;
      st_q.rsvd_b6 <= RST_RESERVED_B6;
      st_q.rsvd_b7 <= RST_RESERVED_B7;
      st_q.rsvd_bb <= RST_RESERVED_BB;
      st_q.ignore_errors_in_filter_wait <= RST_IGNORE_WAIT;
      st_q.count_en <= RST_COUNT_EN;
      st_q.lock_drop_threshold <= RST_THRESHOLD;
      st_q.encoder_crc_disable <= RST_CRC_DISABLE;
      st_q.enc_reserved <= RST_ENC_RESERVED;
      st_q.link_state <= LINK_UNLOCKED;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata     = st_q.rdata;
  assign o_reg_rvalid    = st_q.rvalid;
  assign o_link_lock     = (st_q.link_state == LINK_LOCKED);
  assign o_link_info     = st_q.link_info;
  assign o_link_info_upd = st_q.link_info_upd;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);

  a_index_done_read: assert property (
    i_reg_rd && i_reg_addr == OFS_STRAP_STATUS
    |=> o_reg_rdata[BIT_INDEX_DONE] == $past(strap_done[0]))
    else $error("index done bit misreported");

  a_index_value_read: assert property (
    i_reg_rd && i_reg_addr == OFS_STRAP_STATUS
    |=> o_reg_rdata[6:4] == $past(strap_value[0]))
    else $error("index value misreported");

  a_config_done_read: assert property (
    i_reg_rd && i_reg_addr == OFS_STRAP_STATUS
    |=> o_reg_rdata[BIT_CONFIG_DONE] == $past(strap_done[1]))
    else $error("config done bit misreported");

  a_config_value_read: assert property (
    i_reg_rd && i_reg_addr == OFS_STRAP_STATUS
    |=> o_reg_rdata[2:0] == $past(strap_value[1]))
    else $error("config value misreported");

  a_wait_error_ignored: assert property (
    o_link_lock && i_lock_detect && link_error && i_filter_wait
    && st_q.ignore_errors_in_filter_wait
    |=> o_link_lock && st_q.error_count == $past(st_q.error_count))
    else $error("error in filter wait was not ignored");

  a_count_step: assert property (
    o_link_lock && i_lock_detect && counted_error && st_q.count_en
    && count_inc < {1'b0, st_q.lock_drop_threshold}
    |=> o_link_lock && st_q.error_count == $past(count_inc[3:0]))
    else $error("error count did not step");

  a_threshold_drop: assert property (
    o_link_lock && counted_error && st_q.count_en
    && count_inc >= {1'b0, st_q.lock_drop_threshold}
    |=> !o_link_lock)
    else $error("lock kept at threshold");

  a_first_error_drop: assert property (
    o_link_lock && counted_error && !st_q.count_en |=> !o_link_lock)
    else $error("lock kept after error with counting off");

  a_relock_clears: assert property (
    !o_link_lock ##1 o_link_lock |-> st_q.error_count == 4'h0)
    else $error("count not cleared on relock");

  a_crc_gate: assert property (
    i_enc_valid && !i_enc_crc_ok && !st_q.encoder_crc_disable
    |=> !o_link_info_upd && $stable(o_link_info))
    else $error("failed sequence updated link info");

  // Read answers are one-cycle markers; a missing or stray marker would
  // let the host take stale data for a fresh answer.
  a_read_marker_set: assert property (
    i_reg_rd |=> o_reg_rvalid)
    else $error("read strobe got no answer marker");

  a_read_marker_idle: assert property (
    !i_reg_rd |=> !o_reg_rvalid)
    else $error("answer marker without read strobe");

  a_unmapped_read_zero: assert property (
    i_reg_rd && (i_reg_addr < OFS_RESERVED_B5
    || i_reg_addr > OFS_RESERVED_BB) |=> o_reg_rdata == 8'h00)
    else $error("unmapped offset read nonzero");

  a_err_ctl_top_zero: assert property (
    i_reg_rd && i_reg_addr == OFS_LINK_ERR_CTL
    |=> o_reg_rdata[7:6] == 2'b00)
    else $error("link error control top bits nonzero");

  a_index_latch_held: assert property (
    strap_done[0] |=> strap_done[0] && $stable(strap_value[0]))
    else $error("index strap result changed after latch");

  a_config_latch_held: assert property (
    strap_done[1] |=> strap_done[1] && $stable(strap_value[1]))
    else $error("config strap result changed after latch");

  a_lock_needs_edge: assert property (
    !o_link_lock && !(i_lock_detect && !st_q.lock_detect_prev)
    |=> !o_link_lock)
    else $error("lock taken without detector edge");

  a_detect_loss_drop: assert property (
    o_link_lock && !i_lock_detect |=> !o_link_lock)
    else $error("lock kept after detector loss");

  a_good_seq_taken: assert property (
    i_enc_valid && (i_enc_crc_ok || st_q.encoder_crc_disable)
    |=> o_link_info_upd && o_link_info == $past(i_enc_info))
    else $error("accepted sequence not stored");

  a_count_off_hold: assert property (
    o_link_lock && !st_q.count_en |=> $stable(st_q.error_count))
    else $error("error count moved with counting off");

  c_strap_done: cover property (strap_done == 2'b11);
  c_threshold_drop: cover property (
    o_link_lock && st_q.count_en ##1 !o_link_lock);
  c_wait_ignored: cover property (
    o_link_lock && link_error && i_filter_wait
    && st_q.ignore_errors_in_filter_wait);
  c_crc_skip: cover property (
    i_enc_valid && !i_enc_crc_ok && st_q.encoder_crc_disable);
  c_relock: cover property (!o_link_lock ##1 o_link_lock);
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the link error and strap status register slice.
// Assumes a single 50 MHz clock and reads answered one cycle after strobe.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import link_err_strap_pkg::*;
;
  logic               i_sys_clk, i_reset;
  logic [7:0]         i_reg_addr, i_reg_wdata, i_enc_info;
  logic               i_reg_wr, i_reg_rd, i_enc_valid, i_enc_crc_ok;
  logic               i_index_strap_valid, i_config_strap_valid;
  logic [STRAP_W-1:0] i_index_strap_code, i_config_strap_code;
  logic               i_lock_detect, i_filter_wait;
  logic               i_parity_err, i_clock_err, i_control_err;
  logic [7:0]         o_reg_rdata, o_link_info;
  logic               o_reg_rvalid, o_link_lock, o_link_info_upd;
  int                 mismatches, total_checks;

  link_err_strap_bank link_err_strap_bank_inst (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .i_index_strap_valid(i_index_strap_valid),
    .i_index_strap_code(i_index_strap_code),
    .i_config_strap_valid(i_config_strap_valid),
    .i_config_strap_code(i_config_strap_code),
    .i_lock_detect(i_lock_detect), .i_parity_err(i_parity_err),
    .i_clock_err(i_clock_err), .i_control_err(i_control_err),
    .i_filter_wait(i_filter_wait), .o_link_lock(o_link_lock),
    .i_enc_valid(i_enc_valid), .i_enc_crc_ok(i_enc_crc_ok),
    .i_enc_info(i_enc_info), .o_link_info(o_link_info),
    .o_link_info_upd(o_link_info_upd)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    tick(1);
    i_reg_wr = 1'b0;
    // An idle edge keeps a following strobe from being set in this step.
    tick(1);
  endtask

  // The answer stands one cycle only, so it is sampled in that cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    tick(1);
    i_reg_rd = 1'b0;
    chk("rvalid", 8'h01, {7'h00, o_reg_rvalid});
    chk("rdata", exp, o_reg_rdata);
    tick(1);
  endtask

  task automatic chk_lock(input logic exp);
    chk("link_lock", {7'h00, exp}, {7'h00, o_link_lock});
  endtask

  // Drops the detector for one cycle so that it rises again.
  task automatic relock();
    i_lock_detect = 1'b0;
    tick(1);
    i_lock_detect = 1'b1;
    tick(2);
    chk_lock(1'b1);
  endtask

  task automatic err(input int k);
    i_parity_err = (k == 0);
    i_clock_err = (k == 1);
    i_control_err = (k == 2);
    tick(1);
    {i_parity_err, i_clock_err, i_control_err} = 3'h0;
    tick(2);
  endtask

  task automatic enc(input logic ok, input logic [7:0] info,
                     input logic upd, input logic [7:0] exp);
    i_enc_valid = 1'b1;
    i_enc_crc_ok = ok;
    i_enc_info = info;
    tick(1);
    i_enc_valid = 1'b0;
    chk("link_info_upd", {7'h00, upd}, {7'h00, o_link_info_upd});
    chk("link_info", exp, o_link_info);
    tick(1);
  endtask

  task automatic test_reset_values();
    logic [7:0] a [9] = '{8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA,
                          8'hBB, 8'hB4, 8'hBC};
    logic [7:0] e [9] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h33, 8'h03,
                          8'h74, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++) rd(a[i], e[i]);
  endtask

  task automatic test_access();
    wr(8'hB9, 8'hFF);
    rd(8'hB9, 8'h3F);
    wr(8'hB8, 8'hFF);
    rd(8'hB8, 8'h00);
    wr(8'hB4, 8'h5A);
    rd(8'hB4, 8'h00);
    wr(8'hB6, 8'hA5);
    rd(8'hB6, 8'hA5);
    wr(8'hB9, 8'h33);
  endtask

  // A second decode result must not overwrite the latched one.
  task automatic test_straps();
    {i_index_strap_valid, i_index_strap_code} = 4'hD;
    {i_config_strap_valid, i_config_strap_code} = 4'hA;
    tick(1);
    {i_index_strap_valid, i_config_strap_valid} = 2'h0;
    rd(8'hB8, 8'hDA);
    {i_index_strap_valid, i_index_strap_code} = 4'h9;
    {i_config_strap_valid, i_config_strap_code} = 4'hF;
    tick(1);
    {i_index_strap_valid, i_config_strap_valid} = 2'h0;
    rd(8'hB8, 8'hDA);
  endtask

  task automatic test_threshold();
    relock();
    err(0);
    err(1);
    chk_lock(1'b1);
    err(2);
    chk_lock(1'b0);
    relock();
    err(2);
    err(0);
    chk_lock(1'b1);
  endtask

  task automatic test_modes();
    wr(8'hB9, 8'h23);
    relock();
    err(1);
    chk_lock(1'b0);
    wr(8'hB9, 8'h31);
    relock();
    i_filter_wait = 1'b1;
    err(0);
    chk_lock(1'b1);
    wr(8'hB9, 8'h11);
    err(2);
    chk_lock(1'b0);
    i_filter_wait = 1'b0;
  endtask

  task automatic test_crc();
    enc(1'b1, 8'hAA, 1'b1, 8'hAA);
    enc(1'b0, 8'h55, 1'b0, 8'hAA);
    wr(8'hBA, 8'h83);
    rd(8'hBA, 8'h83);
    enc(1'b0, 8'h55, 1'b1, 8'h55);
    wr(8'hBA, 8'h03);
    rd(8'hBA, 8'h03);
    enc(1'b0, 8'h66, 1'b0, 8'h55);
  endtask

  // Reset in mid-run must restore the register values; lock is already low before it, so the check only sees it stay low.
  task automatic test_mid_reset();
    wr(8'hB6, 8'h5A);
    i_lock_detect = 1'b0;
    i_reset = 1'b1;
    tick(5);
    i_reset = 1'b0;
    chk_lock(1'b0);
    chk("link_info", 8'h00, o_link_info);
    rd(8'hB6, 8'h18);
    rd(8'hB9, 8'h33);
    rd(8'hB8, 8'h00);
    rd(8'hBA, 8'h03);
  endtask

  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end

  initial begin
    {i_reg_addr, i_reg_wdata, i_enc_info} = 24'h0;
    {i_reg_wr, i_reg_rd, i_enc_valid, i_enc_crc_ok} = 4'h0;
    {i_index_strap_valid, i_config_strap_valid} = 2'h0;
    {i_index_strap_code, i_config_strap_code} = 6'h00;
    {i_lock_detect, i_filter_wait} = 2'h0;
    {i_parity_err, i_clock_err, i_control_err} = 3'h0;
    mismatches = 0;
    total_checks = 0;
    i_reset = 1'b1;
    tick(5);
    i_reset = 1'b0;
    test_reset_values();
    test_access();
    test_straps();
    test_threshold();
    test_modes();
    test_crc();
    test_mid_reset();
    print_verdict();
  end
endmodule
`default_nettype wire
